// ===== rtl/cdcr_pkg.sv
// Constants, pointer map and carrier types of the offset, gain and
// offset-cancel register bank.
// Assumes a byte-wide pointer interface supplied by a serial engine.
package cdcr_pkg;
	// Register pointers
	localparam logic [7:0] PTR_POS_DAC = 8'h0b;
	localparam logic [7:0] PTR_NEG_DAC = 8'h0c;
	localparam logic [7:0] PTR_OFFS_HI = 8'h0d;
	localparam logic [7:0] PTR_OFFS_LO = 8'h0e;
	localparam logic [7:0] PTR_CGAIN_HI = 8'h0f;
	localparam logic [7:0] PTR_CGAIN_LO = 8'h10;
	localparam logic [7:0] PTR_VGAIN_HI = 8'h11;
	localparam logic [7:0] PTR_VGAIN_LO = 8'h12;
	// Reset values and read filler
	localparam logic [7:0] DAC_RST = 8'h00;
	localparam logic [15:0] OFFS_RST = 16'h8000;
	localparam logic [15:0] OFFS_ZERO = 16'h8000;
	localparam logic [15:0] GAIN_PRELOAD = 16'h0000;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	// Field layout
	localparam int CONNECT_BIT = 7;
	localparam int CODE_W = 7;
	localparam int COEF_W = 16;
	localparam int RAW_W = 24;
	// Offset LSB is 32 raw LSBs, about 15.6 aF; full span about 1 pF
	localparam int OFFS_SHIFT = 5;
	// Gain is unsigned with 15 fraction bits
	localparam int GAIN_FRAC = 15;
	// Factory storage words
	localparam logic [1:0] OTP_ADDR_CAP = 2'h0;
	localparam logic [1:0] OTP_ADDR_VOLT = 2'h1;

	typedef struct packed {
		logic connect;
		logic [CODE_W-1:0] code;
	} cdcr_dac_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] ptr;
		logic [7:0] wdata;
	} cdcr_bus_s;

	typedef struct packed {
		logic valid;
		logic is_volt;
		logic [RAW_W-1:0] data;
	} cdcr_sample_s;

	typedef struct packed {
		logic cap;
		logic volt;
		logic [COEF_W-1:0] data;
	} cdcr_load_s;
endpackage : cdcr_pkg

// ===== rtl/cdcr_otp_loader.sv
// Copies the two factory gain words out of one-time storage after reset.
// Assumes storage answers a held read request with a one-cycle valid.
`timescale 1ns/100ps
`default_nettype none
module cdcr_otp_loader (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Factory storage port
	output logic o_otp_rd,
	output logic [1:0] o_otp_addr,
	input wire logic i_otp_valid,
	input wire logic [cdcr_pkg::COEF_W-1:0] i_otp_data,
	// Load strobes toward the register bank
	output cdcr_pkg::cdcr_load_s o_load,
	output logic o_done
);
	typedef enum logic [1:0] {
		ST_CAP = 2'b00,
		ST_VOLT = 2'b01,
		ST_DONE = 2'b11
	} cdcr_ld_e;

	typedef struct packed {
		cdcr_ld_e st;
		cdcr_pkg::cdcr_load_s load;
	} cdcr_ld_s;

	cdcr_ld_s state_r;
	cdcr_ld_s state_nxt;

	always_comb begin
		state_nxt = state_r;
		state_nxt.load.cap = 1'b0;
		state_nxt.load.volt = 1'b0;
		unique case (state_r.st)
			ST_CAP: begin
				if (i_otp_valid) begin
					state_nxt.load.cap = 1'b1;
					state_nxt.load.data = i_otp_data;
					state_nxt.st = ST_VOLT;
				end
			end
			ST_VOLT: begin
				if (i_otp_valid) begin
					state_nxt.load.volt = 1'b1;
					state_nxt.load.data = i_otp_data;
					state_nxt.st = ST_DONE;
				end
			end
			ST_DONE: begin
				state_nxt.st = ST_DONE;
			end
			default: begin
				state_nxt.st = ST_CAP;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= '{st: ST_CAP, load: '0};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_otp_rd = (state_r.st != ST_DONE);
	assign o_otp_addr = (state_r.st == ST_VOLT) ? cdcr_pkg::OTP_ADDR_VOLT : cdcr_pkg::OTP_ADDR_CAP;
	assign o_load = state_r.load;
	assign o_done = (state_r.st == ST_DONE);
endmodule : cdcr_otp_loader
`default_nettype wire

// ===== rtl/cdcr_corrector.sv
// Applies the offset and gain coefficients to raw converter samples.
// Assumes samples come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module cdcr_corrector (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Coefficients
	input wire logic [cdcr_pkg::COEF_W-1:0] i_offset,
	input wire logic [cdcr_pkg::COEF_W-1:0] i_cap_gain,
	input wire logic [cdcr_pkg::COEF_W-1:0] i_volt_gain,
	// Samples
	input wire cdcr_pkg::cdcr_sample_s i_raw,
	output cdcr_pkg::cdcr_sample_s o_result
);
	localparam int SUM_W = cdcr_pkg::RAW_W + 2;
	localparam int PROD_W = SUM_W + cdcr_pkg::COEF_W + 1;
	localparam logic signed [PROD_W-1:0] SAT_MAX = PROD_W'(2 ** (cdcr_pkg::RAW_W - 1) - 1);
	localparam logic signed [PROD_W-1:0] SAT_MIN = -PROD_W'(2 ** (cdcr_pkg::RAW_W - 1));

	cdcr_pkg::cdcr_sample_s state_r;
	cdcr_pkg::cdcr_sample_s state_nxt;

	function automatic logic [cdcr_pkg::RAW_W-1:0] sat_raw(input logic signed [PROD_W-1:0] v);
		if (v > SAT_MAX) begin
			sat_raw = SAT_MAX[cdcr_pkg::RAW_W-1:0];
		end else if (v < SAT_MIN) begin
			sat_raw = SAT_MIN[cdcr_pkg::RAW_W-1:0];
		end else begin
			sat_raw = v[cdcr_pkg::RAW_W-1:0];
		end
	endfunction : sat_raw

	always_comb begin
		logic signed [cdcr_pkg::COEF_W:0] delta;
		logic signed [SUM_W-1:0] corr;
		logic signed [PROD_W-1:0] prod;
		delta = '0;
		corr = '0;
		prod = '0;
		state_nxt = state_r;
		state_nxt.valid = i_raw.valid;
		if (i_raw.valid) begin
			// The offset and cap gain serve capacitive samples; voltage samples take only the volt gain
			delta = $signed({1'b0, i_offset}) - $signed({1'b0, cdcr_pkg::OFFS_ZERO});
			corr = SUM_W'($signed(i_raw.data));
			if (!i_raw.is_volt) begin
				corr = corr - (SUM_W'(delta) <<< cdcr_pkg::OFFS_SHIFT);
				prod = PROD_W'(corr) * PROD_W'($signed({1'b0, i_cap_gain}));
			end else begin
				prod = PROD_W'(corr) * PROD_W'($signed({1'b0, i_volt_gain}));
			end
			state_nxt.is_volt = i_raw.is_volt;
			state_nxt.data = sat_raw(prod >>> cdcr_pkg::GAIN_FRAC);
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_result = state_r;
endmodule : cdcr_corrector
`default_nettype wire

// ===== rtl/cdcr_regbank.sv
// Offset-cancel, offset and gain coefficient registers behind a byte pointer.
// Assumes a serial engine on the same clock presents one-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
module cdcr_regbank (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Byte pointer access
	input wire cdcr_pkg::cdcr_bus_s i_bus,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	// Offset calibration result
	input wire logic i_offs_cal_done,
	input wire logic [cdcr_pkg::COEF_W-1:0] i_offs_cal_value,
	// Factory storage
	output logic o_otp_rd,
	output logic [1:0] o_otp_addr,
	input wire logic i_otp_valid,
	input wire logic [cdcr_pkg::COEF_W-1:0] i_otp_data,
	// Conversion data
	input wire cdcr_pkg::cdcr_sample_s i_raw,
	output cdcr_pkg::cdcr_sample_s o_result,
	// Offset-cancel capacitor control and factory load status
	output cdcr_pkg::cdcr_dac_s o_pos_dac,
	output cdcr_pkg::cdcr_dac_s o_neg_dac,
	output logic o_gain_ready
);
	typedef struct packed {
		cdcr_pkg::cdcr_dac_s pos;
		cdcr_pkg::cdcr_dac_s neg;
		logic [cdcr_pkg::COEF_W-1:0] offset;
		logic [cdcr_pkg::COEF_W-1:0] cap_gain;
		logic [cdcr_pkg::COEF_W-1:0] volt_gain;
		logic [7:0] rdata;
		logic rvalid;
	} cdcr_bank_s;

	cdcr_bank_s state_r;
	cdcr_bank_s state_nxt;
	cdcr_pkg::cdcr_load_s load;
	logic loaded;

	// Replace one byte of a coefficient, high byte at the lower pointer
	function automatic logic [15:0] put_byte(
		input logic [15:0] word,
		input logic hi,
		input logic [7:0] b
	);
		if (hi) begin
			put_byte = {b, word[7:0]};
		end else begin
			put_byte = {word[15:8], b};
		end
	endfunction : put_byte

	// Read mux over the pointer map
	function automatic logic [7:0] rd_mux(input cdcr_bank_s s, input logic [7:0] ptr);
		unique case (ptr)
			cdcr_pkg::PTR_POS_DAC: rd_mux = s.pos;
			cdcr_pkg::PTR_NEG_DAC: rd_mux = s.neg;
			cdcr_pkg::PTR_OFFS_HI: rd_mux = s.offset[15:8];
			cdcr_pkg::PTR_OFFS_LO: rd_mux = s.offset[7:0];
			cdcr_pkg::PTR_CGAIN_HI: rd_mux = s.cap_gain[15:8];
			cdcr_pkg::PTR_CGAIN_LO: rd_mux = s.cap_gain[7:0];
			cdcr_pkg::PTR_VGAIN_HI: rd_mux = s.volt_gain[15:8];
			cdcr_pkg::PTR_VGAIN_LO: rd_mux = s.volt_gain[7:0];
			default: rd_mux = cdcr_pkg::UNMAPPED_RD;
		endcase
	endfunction : rd_mux

	cdcr_otp_loader u_loader (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.o_otp_rd(o_otp_rd),
		.o_otp_addr(o_otp_addr),
		.i_otp_valid(i_otp_valid),
		.i_otp_data(i_otp_data),
		.o_load(load),
		.o_done(loaded)
	);

	always_comb begin
		state_nxt = state_r;
		state_nxt.rvalid = i_bus.rd;
		if (i_bus.rd) begin
			state_nxt.rdata = rd_mux(state_r, i_bus.ptr);
		end
		if (i_bus.wr) begin
			unique case (i_bus.ptr)
				cdcr_pkg::PTR_POS_DAC: begin
					state_nxt.pos = i_bus.wdata;
				end
				cdcr_pkg::PTR_NEG_DAC: begin
					state_nxt.neg = i_bus.wdata;
				end
				cdcr_pkg::PTR_OFFS_HI, cdcr_pkg::PTR_OFFS_LO: begin
					state_nxt.offset = put_byte(state_r.offset,
						i_bus.ptr == cdcr_pkg::PTR_OFFS_HI, i_bus.wdata);
				end
				cdcr_pkg::PTR_CGAIN_HI, cdcr_pkg::PTR_CGAIN_LO: begin
					state_nxt.cap_gain = put_byte(state_r.cap_gain,
						i_bus.ptr == cdcr_pkg::PTR_CGAIN_HI, i_bus.wdata);
				end
				cdcr_pkg::PTR_VGAIN_HI, cdcr_pkg::PTR_VGAIN_LO: begin
					state_nxt.volt_gain = put_byte(state_r.volt_gain,
						i_bus.ptr == cdcr_pkg::PTR_VGAIN_HI, i_bus.wdata);
				end
				default: begin
					state_nxt.rdata = state_nxt.rdata;
				end
			endcase
		end
		// Calibration result beats a host write in the same cycle
		if (i_offs_cal_done) begin
			state_nxt.offset = i_offs_cal_value;
		end
		// Factory load beats a host write in the same cycle
		if (load.cap) begin
			state_nxt.cap_gain = load.data;
		end
		if (load.volt) begin
			state_nxt.volt_gain = load.data;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r.pos <= cdcr_pkg::DAC_RST;
			state_r.neg <= cdcr_pkg::DAC_RST;
			state_r.offset <= cdcr_pkg::OFFS_RST;
			state_r.cap_gain <= cdcr_pkg::GAIN_PRELOAD;
			state_r.volt_gain <= cdcr_pkg::GAIN_PRELOAD;
			state_r.rdata <= cdcr_pkg::UNMAPPED_RD;
			state_r.rvalid <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	cdcr_corrector u_corr (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_offset(state_r.offset),
		.i_cap_gain(state_r.cap_gain),
		.i_volt_gain(state_r.volt_gain),
		.i_raw(i_raw),
		.o_result(o_result)
	);

	assign o_rdata = state_r.rdata;
	assign o_rvalid = state_r.rvalid;
	assign o_pos_dac = state_r.pos;
	assign o_neg_dac = state_r.neg;
	assign o_gain_ready = loaded;

	// Checks
	sequence wr_to(logic [7:0] p);
		i_bus.wr && i_bus.ptr == p && !i_offs_cal_done && !load.cap && !load.volt;
	endsequence

	sequence rd_at(logic [7:0] p);
		i_bus.rd && !i_bus.wr && i_bus.ptr == p && !i_offs_cal_done;
	endsequence

	pos_connect_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_to(cdcr_pkg::PTR_POS_DAC) |=> o_pos_dac.connect == $past(i_bus.wdata[7]))
		else $error("positive connect bit not taken");

	pos_code_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_to(cdcr_pkg::PTR_POS_DAC)
		##1 !(i_bus.wr && i_bus.ptr == cdcr_pkg::PTR_POS_DAC) [*2]
		|-> o_pos_dac.code == $past(i_bus.wdata[6:0], 2))
		else $error("positive code not held");

	neg_connect_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_to(cdcr_pkg::PTR_NEG_DAC) |=> o_neg_dac == $past(i_bus.wdata))
		else $error("negative setting not taken");

	neg_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		rd_at(cdcr_pkg::PTR_NEG_DAC) |=> o_rvalid && o_rdata == o_neg_dac)
		else $error("negative setting read wrong");

	offs_bytes_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		rd_at(cdcr_pkg::PTR_OFFS_HI) |=> o_rdata == $past(state_r.offset[15:8]))
		else $error("offset high byte not at lower pointer");

	offs_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_to(cdcr_pkg::PTR_OFFS_LO) |=> state_r.offset[7:0] == $past(i_bus.wdata)
		&& state_r.offset[15:8] == $past(state_r.offset[15:8]))
		else $error("offset low byte write wrong");

	cal_overwrite_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_offs_cal_done |=> state_r.offset == $past(i_offs_cal_value))
		else $error("calibration did not overwrite offset");

	result_time_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_raw.valid |=> o_result.valid && o_result.is_volt == $past(i_raw.is_volt))
		else $error("corrected result late");

	zero_offset_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_raw.valid && !i_raw.is_volt && state_r.offset == cdcr_pkg::OFFS_ZERO
		&& state_r.cap_gain == (16'h0001 << cdcr_pkg::GAIN_FRAC)
		|=> o_result.data == $past(i_raw.data))
		else $error("neutral offset changed the result");

	sequence otp_cap_load;
		o_otp_rd && o_otp_addr == cdcr_pkg::OTP_ADDR_CAP && i_otp_valid;
	endsequence

	gain_load_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		otp_cap_load |=> ##1 state_r.cap_gain == $past(i_otp_data, 2))
		else $error("factory gain not copied");

	cgain_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		rd_at(cdcr_pkg::PTR_CGAIN_LO) ##0 !load.cap |=> o_rdata == $past(state_r.cap_gain[7:0]))
		else $error("cap gain low byte read wrong");

	vgain_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		rd_at(cdcr_pkg::PTR_VGAIN_HI) |=> o_rdata == $past(state_r.volt_gain[15:8]))
		else $error("volt gain high byte read wrong");

	sequence otp_volt_load;
		o_otp_rd && o_otp_addr == cdcr_pkg::OTP_ADDR_VOLT && i_otp_valid;
	endsequence

	load_time_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		otp_volt_load |=> o_gain_ready && !o_otp_rd)
		else $error("factory load did not finish");

	load_order_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		otp_cap_load |=> o_otp_rd && o_otp_addr == cdcr_pkg::OTP_ADDR_VOLT && !o_gain_ready)
		else $error("factory words out of order");

	vgain_load_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		otp_volt_load |=> ##1 state_r.volt_gain == $past(i_otp_data, 2))
		else $error("factory volt gain not copied");

	gain_keep_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_gain_ready && !(i_bus.wr && (i_bus.ptr == cdcr_pkg::PTR_CGAIN_HI
		|| i_bus.ptr == cdcr_pkg::PTR_CGAIN_LO)) |=> $stable(state_r.cap_gain))
		else $error("cap gain changed without a write");

	pos_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		rd_at(cdcr_pkg::PTR_POS_DAC) |=> o_rvalid && o_rdata == $past(o_pos_dac))
		else $error("positive setting read wrong");

	neg_code_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_to(cdcr_pkg::PTR_NEG_DAC) |=> o_neg_dac.code == $past(i_bus.wdata[cdcr_pkg::CODE_W-1:0]))
		else $error("negative code not taken");

	pos_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!(i_bus.wr && i_bus.ptr == cdcr_pkg::PTR_POS_DAC) |=> $stable(o_pos_dac))
		else $error("positive setting changed without a write");

	neg_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!(i_bus.wr && i_bus.ptr == cdcr_pkg::PTR_NEG_DAC) |=> $stable(o_neg_dac))
		else $error("negative setting changed without a write");

	offs_hi_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_to(cdcr_pkg::PTR_OFFS_HI) |=> state_r.offset[15:8] == $past(i_bus.wdata)
		&& state_r.offset[7:0] == $past(state_r.offset[7:0]))
		else $error("offset high byte write wrong");

	offs_lo_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		rd_at(cdcr_pkg::PTR_OFFS_LO) |=> o_rdata == $past(state_r.offset[7:0]))
		else $error("offset low byte read wrong");

	cal_wins_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_offs_cal_done && i_bus.wr && (i_bus.ptr == cdcr_pkg::PTR_OFFS_HI
		|| i_bus.ptr == cdcr_pkg::PTR_OFFS_LO) |=> state_r.offset == $past(i_offs_cal_value))
		else $error("host write beat the calibration");

	cgain_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_to(cdcr_pkg::PTR_CGAIN_LO) |=> state_r.cap_gain == {$past(state_r.cap_gain[15:8]), $past(i_bus.wdata)})
		else $error("cap gain low byte write wrong");

	cgain_hi_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_to(cdcr_pkg::PTR_CGAIN_HI) |=> state_r.cap_gain[15:8] == $past(i_bus.wdata)
		&& state_r.cap_gain[7:0] == $past(state_r.cap_gain[7:0]))
		else $error("cap gain high byte write wrong");

	cgain_hi_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		rd_at(cdcr_pkg::PTR_CGAIN_HI) ##0 !load.cap |=> o_rdata == $past(state_r.cap_gain[15:8]))
		else $error("cap gain high byte read wrong");

	vgain_lo_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		rd_at(cdcr_pkg::PTR_VGAIN_LO) |=> o_rdata == $past(state_r.volt_gain[7:0]))
		else $error("volt gain low byte read wrong");

	result_idle_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!i_raw.valid |=> !o_result.valid)
		else $error("result without a sample");
endmodule : cdcr_regbank
`default_nettype wire

// ===== sim/cdcr_otp_model.sv
// Behavioural factory storage that answers the gain preload requests.
// Assumes the loader holds its request until a word comes back.
`timescale 1ns/100ps
`default_nettype none
module cdcr_otp_model #(
	parameter logic [15:0] CAP_WORD = 16'h9a3c,
	parameter logic [15:0] VOLT_WORD = 16'h4000
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Request, answer and answer delay
	input wire logic i_rd,
	input wire logic [1:0] i_addr,
	input wire logic [3:0] i_lat,
	output logic o_valid,
	output logic [15:0] o_data
);
	logic [3:0] cnt_r;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_r <= 4'h0;
			o_valid <= 1'b0;
			o_data <= 16'h5a5a;
		end else begin
			o_valid <= 1'b0;
			o_data <= ~o_data;
			if (i_rd && !o_valid) begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r >= i_lat) begin
					cnt_r <= 4'h0;
					o_valid <= 1'b1;
					o_data <= (i_addr == 2'h0) ? CAP_WORD : VOLT_WORD;
				end
			end
		end
	end
endmodule : cdcr_otp_model
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench of the coefficient register bank.
// Assumes the factory storage model beside it.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [15:0] CAP_W = 16'h9a3c;
	localparam logic [15:0] VOLT_W = 16'h4000;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	cdcr_pkg::cdcr_bus_s bus;
	cdcr_pkg::cdcr_sample_s raw;
	cdcr_pkg::cdcr_sample_s res;
	cdcr_pkg::cdcr_dac_s pos;
	cdcr_pkg::cdcr_dac_s neg;
	logic [7:0] rdata;
	logic rvalid;
	logic cal_done;
	logic [15:0] cal_val;
	logic otp_rd;
	logic [1:0] otp_addr;
	logic otp_valid;
	logic [15:0] otp_data;
	logic gain_ready;
	logic [3:0] lat;
	int fails = 0;
	int comparisons = 0;
	int seed = 32'hc9b08722;
	logic [7:0] qb[$];
	logic [23:0] qs[$];
	logic [15:0] offs;
	logic [15:0] cg;
	logic [15:0] v;
	logic [7:0] b;
	logic [7:0] tab [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};

	always #5 clk = ~clk;

	cdcr_regbank dut_u (.i_clk(clk), .i_nrst(nrst), .i_bus(bus), .o_rdata(rdata),
		.o_rvalid(rvalid), .i_offs_cal_done(cal_done), .i_offs_cal_value(cal_val),
		.o_otp_rd(otp_rd), .o_otp_addr(otp_addr), .i_otp_valid(otp_valid),
		.i_otp_data(otp_data), .i_raw(raw), .o_result(res), .o_pos_dac(pos),
		.o_neg_dac(neg), .o_gain_ready(gain_ready));
	cdcr_otp_model #(.CAP_WORD(CAP_W), .VOLT_WORD(VOLT_W)) otp_u (.i_clk(clk),
		.i_nrst(nrst), .i_rd(otp_rd), .i_addr(otp_addr), .i_lat(lat),
		.o_valid(otp_valid), .o_data(otp_data));

	task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_b

	task automatic chk_s(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_s

	always @(negedge clk) begin
		if (rvalid === 1'b1) chk_b(rdata, qb.pop_front());
		if (res.valid === 1'b1) chk_s(res.data, qs.pop_front());
	end

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		@(posedge clk);
		bus <= '{1'b1, 1'b0, p, d};
		@(posedge clk);
		bus <= '0;
	endtask : wr

	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		qb.push_back(e);
		@(posedge clk);
		bus <= '{1'b0, 1'b1, p, 8'h00};
		@(posedge clk);
		bus <= '0;
	endtask : rd

	// Queues the corrected value, then presents the raw sample
	task automatic smp(input logic vt, input logic [23:0] d);
		longint p;
		p = longint'($signed(d));
		if (vt) p = p * longint'(VOLT_W);
		else p = (p - ((longint'(offs) - 32768) <<< 5)) * longint'(cg);
		p = p >>> 15;
		if (p > 8388607) p = 8388607;
		if (p < -8388608) p = -8388608;
		qs.push_back(p[23:0]);
		@(posedge clk);
		raw <= '{1'b1, vt, d};
		@(posedge clk);
		raw <= '0;
	endtask : smp

	task automatic wait_ready;
		for (int i = 0; i < 80; i++) begin
			if (gain_ready === 1'b1) break;
			@(negedge clk);
		end
		chk_b({7'h00, gain_ready}, 8'h01);
		repeat (2) @(posedge clk);
	endtask : wait_ready

	task automatic summarize;
		if (qb.size() != 0 || qs.size() != 0) fails++;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	initial begin
		#100000;
		fails++;
		summarize();
	end

	initial begin
		bus = '0;
		raw = '0;
		cal_done = 1'b0;
		cal_val = 16'h0000;
		lat = 4'h0;
		offs = 16'h8000;
		cg = CAP_W;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		chk_b(pos, 8'h00);
		chk_b(neg, 8'h00);
		wait_ready();
		rd(8'h0b, 8'h00);
		rd(8'h0c, 8'h00);
		rd(8'h0d, 8'h80);
		rd(8'h0e, 8'h00);
		rd(8'h0f, CAP_W[15:8]);
		rd(8'h10, CAP_W[7:0]);
		rd(8'h11, VOLT_W[15:8]);
		rd(8'h12, VOLT_W[7:0]);
		rd(8'h13, 8'h00);
		rd(8'h0a, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 6; i++) begin
			b = (i < 4) ? tab[i] : 8'($random(seed));
			wr(8'h0b, b);
			wr(8'h0c, ~b);
			#1;
			chk_b(pos, b);
			chk_b(neg, ~b);
			rd(8'h0b, b);
			rd(8'h0c, ~b);
		end
		$display("test cancel settings done");
		wr(8'h0d, 8'h81);
		wr(8'h0e, 8'h23);
		offs = 16'h8123;
		rd(8'h0d, 8'h81);
		rd(8'h0e, 8'h23);
		smp(1'b0, 24'h001000);
		v = 16'($random(seed));
		@(posedge clk);
		cal_done <= 1'b1;
		cal_val <= v;
		bus <= '{1'b1, 1'b0, 8'h0d, 8'h00};
		@(posedge clk);
		cal_done <= 1'b0;
		bus <= '0;
		offs = v;
		rd(8'h0d, v[15:8]);
		rd(8'h0e, v[7:0]);
		smp(1'b0, 24'($random(seed)));
		wr(8'h0d, 8'h80);
		wr(8'h0e, 8'h00);
		offs = 16'h8000;
		smp(1'b0, 24'h7ff000);
		$display("test offset done");
		cg = 16'($random(seed));
		wr(8'h0f, cg[15:8]);
		wr(8'h10, cg[7:0]);
		rd(8'h0f, cg[15:8]);
		rd(8'h10, cg[7:0]);
		for (int i = 0; i < 8; i++) begin
			smp(i[0], 24'($random(seed)));
		end
		wr(8'h0f, 8'h80);
		wr(8'h10, 8'h00);
		cg = 16'h8000;
		smp(1'b0, 24'($random(seed)));
		$display("test samples done");
		repeat (2) @(posedge clk);
		lat <= 4'h5;
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		offs = 16'h8000;
		cg = CAP_W;
		chk_b(pos, 8'h00);
		wait_ready();
		rd(8'h0f, CAP_W[15:8]);
		rd(8'h0d, 8'h80);
		smp(1'b0, 24'h000400);
		repeat (4) @(posedge clk);
		$display("test second reset done");
		summarize();
	end
endmodule : testbench
`default_nettype wire
